// ---- pkg/rom_id_map.svh ----
/*
 Register offsets, field positions and fixed values of the debug ROM
 table identification words. Assumes inclusion by bare name.
*/
`ifndef ROM_ID_MAP_SVH
`define ROM_ID_MAP_SVH

`define ADDR_W 13
`define OFF_TERMINATOR 13'h1008
`define OFF_MEMORY_TYPE 13'h1FCC
`define OFF_IDENT_FOUR 13'h1FD0
`define OFF_IDENT_ZERO 13'h1FE0
`define OFF_IDENT_ONE 13'h1FE4
`define TERMINATOR_VAL 32'h00000000
`define MEM_PRESENT_BIT 0
`define READ_ZERO 32'h00000000
`define ALIGN_MSB 1
`define NIBBLE_MSB 3
`define UPPER_NIBBLE_LSB 4
`define BYTE_MSB 7
`define PART_LOW_MSB 7
`define PART_HIGH_LSB 8
`define PART_HIGH_MSB 11
`define MASK_WORD 32'hFFFFFFFF
`define MASK_FLAG 32'h00000001
`define MASK_BYTE 32'h000000FF
`define BLOCK_COUNT_VAL 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- pkg/rom_id_pkg.sv ----
/*
 Types shared by the debug ROM table identification block.
 Assumes nothing of its surroundings.
*/
package rom_id_pkg;
   typedef enum logic [2:0] {
      REG_TERMINATOR,
      REG_MEMORY_TYPE,
      REG_IDENT_FOUR,
      REG_IDENT_ZERO,
      REG_IDENT_ONE,
      REG_NONE
   } reg_sel_t;
endpackage

// ---- verilog/rom_id_regs.sv ----
/*
 Read-only identification words at the tail of the debug ROM table,
 reached over an AXI4-Lite slave port.
 Assumes aclk at 50 MHz, synchronous active-low aresetn, and a
 protection level that is stable while aresetn is low (power-up).
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rom_id_map.svh"

module rom_id_regs #(
   // Arbitrary identity values, not those of any real maker or part
   parameter logic [3:0] MAKER_CONTINUATION = 4'h0,
   parameter logic [3:0] MAKER_IDENTITY_LOW = 4'h5,
   parameter logic [11:0] PART_NUMBER = 12'h123
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic device_protected,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic rom_id_pkg::reg_sel_t decode(
      input logic [31:0] addr
   );
      logic [`ADDR_W-1:0] a;
      a = addr[`ADDR_W-1:0];
      if (addr[`ALIGN_MSB:0] != '0 || addr[31:`ADDR_W] != '0) begin
         return rom_id_pkg::REG_NONE;
      end
      unique case (a)
         `OFF_TERMINATOR: return rom_id_pkg::REG_TERMINATOR;
         `OFF_MEMORY_TYPE: return rom_id_pkg::REG_MEMORY_TYPE;
         `OFF_IDENT_FOUR: return rom_id_pkg::REG_IDENT_FOUR;
         `OFF_IDENT_ZERO: return rom_id_pkg::REG_IDENT_ZERO;
         `OFF_IDENT_ONE: return rom_id_pkg::REG_IDENT_ONE;
         default: return rom_id_pkg::REG_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Protection latch: caught while reset is held, frozen after release

   logic system_memory_present_q;

   // The level at the last reset edge is the power-up level; a later
   // change of the pin must not reopen system memory to the adapter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         system_memory_present_q <= !device_protected;
      end else begin
         system_memory_present_q <= system_memory_present_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word builders

   function automatic logic [31:0] flag_word(
      input logic flag
   );
      logic [31:0] word;
      word = `READ_ZERO;
      word[`MEM_PRESENT_BIT] = flag;
      return word;
   endfunction

   function automatic logic [31:0] nibble_pair_word(
      input logic [`NIBBLE_MSB:0] upper,
      input logic [`NIBBLE_MSB:0] lower
   );
      logic [31:0] word;
      word = `READ_ZERO;
      word[`BYTE_MSB:`UPPER_NIBBLE_LSB] = upper;
      word[`NIBBLE_MSB:0] = lower;
      return word;
   endfunction

   function automatic logic [31:0] byte_word(
      input logic [`BYTE_MSB:0] field
   );
      logic [31:0] word;
      word = `READ_ZERO;
      word[`BYTE_MSB:0] = field;
      return word;
   endfunction

   // Bits that a register implements; everything else is reserved
   function automatic logic [31:0] implemented_mask(
      input rom_id_pkg::reg_sel_t sel
   );
      logic [31:0] mask;
      mask = `READ_ZERO;
      unique case (sel)
         rom_id_pkg::REG_TERMINATOR: begin
            mask = `MASK_WORD;
         end
         rom_id_pkg::REG_MEMORY_TYPE: begin
            mask = `MASK_FLAG;
         end
         rom_id_pkg::REG_IDENT_FOUR,
         rom_id_pkg::REG_IDENT_ZERO,
         rom_id_pkg::REG_IDENT_ONE: begin
            mask = `MASK_BYTE;
         end
         rom_id_pkg::REG_NONE: begin
            mask = `READ_ZERO;
         end
      endcase
      return mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Read data mux

   rom_id_pkg::reg_sel_t read_sel;
   logic [31:0] read_raw;
   logic [31:0] read_keep;
   logic [31:0] read_word;
   logic read_hit;

   assign read_sel = decode(s_axi_araddr);
   assign read_keep = implemented_mask(read_sel);

   always_comb begin
      read_raw = `READ_ZERO;
      read_hit = 1'h1;
      unique case (read_sel)
         rom_id_pkg::REG_TERMINATOR: begin
            read_raw = `TERMINATOR_VAL;
         end
         rom_id_pkg::REG_MEMORY_TYPE: begin
            read_raw = flag_word(system_memory_present_q);
         end
         rom_id_pkg::REG_IDENT_FOUR: begin
            read_raw = nibble_pair_word(`BLOCK_COUNT_VAL,
                                        MAKER_CONTINUATION);
         end
         rom_id_pkg::REG_IDENT_ZERO: begin
            read_raw = byte_word(
               PART_NUMBER[`PART_LOW_MSB:0]);
         end
         rom_id_pkg::REG_IDENT_ONE: begin
            read_raw = nibble_pair_word(MAKER_IDENTITY_LOW,
               PART_NUMBER[`PART_HIGH_MSB:`PART_HIGH_LSB]);
         end
         rom_id_pkg::REG_NONE: begin
            read_hit = 1'h0;
         end
      endcase
   end

   // Every bit passes its own mask, so no builder can leak a reserved bit
   for (genvar b = 0; b < 32; b++) begin : g_reserved
      assign read_word[b] = read_raw[b] & read_keep[b];
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one read in flight, address taken only when idle

   typedef enum logic [1:0] {
      RD_IDLE,
      RD_TAKE,
      RD_ANSWER
   } read_state_t;

   read_state_t rd_state_q;
   read_state_t rd_state_d;

   always_comb begin
      rd_state_d = rd_state_q;
      unique case (rd_state_q)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               rd_state_d = RD_TAKE;
            end
         end
         RD_TAKE: begin
            // A master that drops arvalid here has cancelled; go idle
            if (s_axi_arvalid) begin
               rd_state_d = RD_ANSWER;
            end else begin
               rd_state_d = RD_IDLE;
            end
         end
         RD_ANSWER: begin
            if (s_axi_rready) begin
               rd_state_d = RD_IDLE;
            end
         end
         default: begin
            rd_state_d = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= RD_IDLE;
      end else begin
         rd_state_q <= rd_state_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h0;
      end else begin
         s_axi_arready <= rd_state_d == RD_TAKE;
         s_axi_rvalid <= rd_state_d == RD_ANSWER;
      end
   end

   // Word and response are caught at the edge that takes the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= `READ_ZERO;
         s_axi_rresp <= `RESP_OKAY;
      end else if (rd_state_q == RD_TAKE && s_axi_arvalid) begin
         s_axi_rdata <= read_word;
         s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel: both halves taken together, data discarded

   typedef enum logic [1:0] {
      WR_IDLE,
      WR_TAKE,
      WR_ANSWER
   } write_state_t;

   write_state_t wr_state_q;
   write_state_t wr_state_d;
   logic write_hit;

   assign write_hit = decode(s_axi_awaddr) != rom_id_pkg::REG_NONE;

   // Waiting for both halves keeps the response tied to one address
   always_comb begin
      wr_state_d = wr_state_q;
      unique case (wr_state_q)
         WR_IDLE: begin
            if (s_axi_awvalid && s_axi_wvalid) begin
               wr_state_d = WR_TAKE;
            end
         end
         WR_TAKE: begin
            if (s_axi_awvalid) begin
               wr_state_d = WR_ANSWER;
            end else begin
               wr_state_d = WR_IDLE;
            end
         end
         WR_ANSWER: begin
            if (s_axi_bready) begin
               wr_state_d = WR_IDLE;
            end
         end
         default: begin
            wr_state_d = WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= WR_IDLE;
      end else begin
         wr_state_q <= wr_state_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'h0;
         s_axi_wready <= 1'h0;
      end else begin
         s_axi_awready <= wr_state_d == WR_TAKE;
         s_axi_wready <= wr_state_d == WR_TAKE;
      end
   end

   // Nothing is stored; the write is only answered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         s_axi_bvalid <= wr_state_d == WR_ANSWER;
         if (wr_state_q == WR_TAKE && s_axi_awvalid) begin
            s_axi_bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

endmodule

// ---- testbench/rom_id_props.sv ----
/* Checker bound to rom_id_regs.
   Assumes only the ports of that module. */
`timescale 1ns/1ps
module rom_id_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic device_protected,
   input wire logic [31:0] s_axi_araddr, s_axi_awaddr, s_axi_rdata,
   input wire logic [1:0] s_axi_rresp, s_axi_bresp,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_bvalid
);
   logic prot_q;
   // Level held during reset counts as the power-up level
   always_ff @(posedge aclk) if (!aresetn) prot_q <= device_protected;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd(a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   term_zero_a: assert property (rd(32'h1008) |=> !s_axi_rdata)
      else $error("terminator");
   mem_bit_a: assert property (rd(32'h1FCC) |=>
      s_axi_rdata == {31'h0, !prot_q}) else $error("memory type");
   four_top_a: assert property (rd(32'h1FD0) |=> !s_axi_rdata[31:4])
      else $error("ident four");
   zero_top_a: assert property (rd(32'h1FE0) |=> !s_axi_rdata[31:8])
      else $error("ident zero");
   one_top_a: assert property (rd(32'h1FE4) |=> !s_axi_rdata[31:8])
      else $error("ident one");
   unmapped_read_a: assert property (rd(32'h1FC8) |=>
      s_axi_rresp == 2'h2 && !s_axi_rdata) else $error("unmapped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no read answer");
   wr_okay_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_awaddr == 32'h1FCC |=> s_axi_bvalid && s_axi_bresp == 2'h0)
      else $error("write answer");
endmodule
bind rom_id_regs rom_id_props rom_id_props_inst (.*);

// ---- testbench/debug_adapter.sv ----
/* Debug adapter model: AXI4-Lite master, one read and one write task.
   Assumes a slave on the same aclk; protection stays zero, writes
   carry every byte strobe. */
`timescale 1ns/1ps
module debug_adapter (
   input wire logic aclk,
   input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
   input wire logic s_axi_arready, s_axi_rvalid,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   output logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr,
   output logic [2:0] s_axi_awprot, s_axi_arprot,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
   output logic s_axi_arvalid, s_axi_rready
);
   initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot,
      s_axi_arprot, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid,
      s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   task automatic rd(input logic [31:0] a, output logic [33:0] v);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_arvalid);
      while (!s_axi_rvalid) @(posedge aclk);
      v = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'h0;
   endtask
   task automatic wr(input logic [31:0] a, d, output logic [1:0] b);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_awvalid | s_axi_wvalid);
      while (!s_axi_bvalid) @(posedge aclk);
      b = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
endmodule

// ---- testbench/tb_top.sv ----
/* Bench: resets at both protection levels, reads every word, writes.
   Assumes debug_adapter drives the bus and the checker is bound. */
`timescale 1ns/1ps
module tb_top;
   // Arbitrary identity values, unlike any real maker or part
   localparam logic [3:0] CONT = 4'h3;
   localparam logic [3:0] IDLO = 4'h9;
   localparam logic [11:0] PART = 12'h4A6;
   logic aclk, aresetn, device_protected;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, b;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [33:0] v;
   int failures, check_count;
   rom_id_regs #(.MAKER_CONTINUATION(CONT), .MAKER_IDENTITY_LOW(IDLO),
      .PART_NUMBER(PART)) rom_id_regs_inst (.*);
   debug_adapter debug_adapter_inst (.*);
   initial begin
      aclk = 1'h0;
      forever #10 aclk = ~aclk;
   end
   task chk(input logic [33:0] got, exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Later level changes must not move the memory-present bit
   task boot(input logic p);
      @(posedge aclk);
      aresetn <= 1'h0;
      device_protected <= p;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      device_protected <= !p;
      debug_adapter_inst.rd(32'h1FCC, v);
      chk(v, {33'h0, !p});
   endtask
   task ids;
      logic [31:0] ad [7];
      logic [33:0] ex [7];
      ad = '{32'h1008, 32'h1FD0, 32'h1FE0, 32'h1FE4, 32'h1FC8,
         32'h1FCE, 32'h3008};
      ex = '{34'h0, {30'h0, CONT}, {26'h0, PART[7:0]},
         {26'h0, IDLO, PART[11:8]}, {2'h2, 32'h0}, {2'h2, 32'h0},
         {2'h2, 32'h0}};
      for (int i = 0; i < 7; i++) begin
         debug_adapter_inst.rd(ad[i], v);
         chk(v, ex[i]);
      end
   endtask
   task wrs;
      debug_adapter_inst.wr(32'h1FCC, 32'h1, b);
      chk({32'h0, b}, 34'h0);
      debug_adapter_inst.wr(32'h1FE0, 32'hFF, b);
      chk({32'h0, b}, 34'h0);
      debug_adapter_inst.wr(32'h1FC0, 32'hFF, b);
      chk({32'h0, b}, 34'h2);
      debug_adapter_inst.rd(32'h1FCC, v);
      chk(v, 34'h0);
   endtask
   initial begin
      aresetn = 1'h0;
      device_protected = 1'h0;
      boot(1'h0);
      ids();
      boot(1'h1);
      wrs();
      ids();
      close_out();
   end
   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule
